// File: logic/midcourse_pkg.sv
/*
 * Shared constants and carrier types for the midcourse maneuver sequencer:
 * register map, field positions, event minutes, decoder counts and the
 * packed structs that group the command link, overflows and outputs.
 * Assumes a single 50 MHz clock domain and a word-wide AHB-Lite bus.
 */
// Functional notes
// - Start command activates sequencer, emits time zero.
// - Minute counter advances once per minute tick.
// - Each event fires once until re-armed.
// - Events at 60, 82, 104, 110 minutes.
// - Timing indicator set by pitch, roll and burn, cleared by end or overflow.
// - Counter overflow at 199 returns to idle.
// - Time zero sets the gyro output.
// - Minute 60 sets inertial, pitch, starts pitch.
// - Register turn-on copies stored polarity to output.
// - Pitch overflow clears polarity and pitch select.
// - Minute 82 selects roll; roll overflow clears.
// - Pitch and roll selects never both set.
// - Minute 104 ignites motor, enables velocity counting.
// - Velocity overflow pulses motor cutoff.
// - Minute 110 clears turn, gyro, inertial outputs.
// - Address register keeps command bits four, five.
// - Address powers registers only during bits 6-17.
// - Bit eighteen loads polarity, turn-on transfers it.
// - Polarity set means positive turn.
// - Alert returns all decoder flip-flops to initial.
// - Six-state and three-state sections count 18 bits.
// - Parity toggles on ones, odd gives parity good.
package midcourse_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses) and fields.
	// ------------------------------------------------------------------
	localparam logic [7:0]  ADDR_CONTROL   = 8'h00;     // Start strobe and input enable.
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;     // Sequencer state, minute and outputs.
	localparam logic [7:0]  ADDR_DECODER   = 8'h08;     // Serial decoder flip-flops.
	localparam int          CTRL_START_BIT = 0;         // Write one to start a sequence.
	localparam int          CTRL_EXT_EN_BIT = 1;        // Lets the start pin act.
	localparam logic        CTRL_EXT_EN_RESET = 1'h1;   // Start pin enabled after reset.
	localparam int          STAT_ACTIVE_BIT = 0;        // Sequencer active.
	localparam int          STAT_MINUTE_LSB = 8;        // Eight-bit minute count.
	localparam int          STAT_RELAY_LSB  = 16;       // Eight relay output bits.
	localparam int          STAT_POWER_LSB  = 24;       // Six duration control bits.
	localparam int          DEC_LO_LSB      = 0;        // Six-state section.
	localparam int          DEC_HI_LSB      = 4;        // Three-state section.
	localparam int          DEC_ADDR_LSB    = 8;        // Two address flip-flops.
	localparam int          DEC_PARITY_BIT  = 12;       // Parity flip-flop.
	localparam int          DEC_PPOL_BIT    = 16;       // Pitch polarity store.
	localparam int          DEC_RPOL_BIT    = 17;       // Roll polarity store.

	// ------------------------------------------------------------------
	// Minute offsets of the sequence events.
	// ------------------------------------------------------------------
	localparam logic [7:0]  EV_PITCH_MIN    = 8'h3C;    // 60 minutes.
	localparam logic [7:0]  EV_ROLL_MIN     = 8'h52;    // 82 minutes.
	localparam logic [7:0]  EV_BURN_MIN     = 8'h68;    // 104 minutes.
	localparam logic [7:0]  EV_END_MIN      = 8'h6E;    // 110 minutes.
	localparam logic [7:0]  MINUTE_OVERFLOW = 8'hC7;    // 199 minutes.
	localparam logic [7:0]  MINUTE_STEP     = 8'h01;

	// ------------------------------------------------------------------
	// Serial decoder counts and address codes (bits four and five).
	// ------------------------------------------------------------------
	localparam logic [2:0]  LO_LAST         = 3'h5;     // Six states 0..5.
	localparam logic [2:0]  LO_CARRY        = 3'h4;     // Fifth state moves the high section.
	localparam logic [1:0]  HI_LAST         = 2'h2;     // Three states 0..2.
	localparam logic [4:0]  ADDR_BITS       = 5'h05;    // Bits one to five are address.
	localparam logic [4:0]  WINDOW_LAST     = 5'h10;    // Bits received before bit 17.
	localparam logic [4:0]  POLARITY_PREV   = 5'h11;    // Bits received before bit 18.
	localparam logic [1:0]  ADDRESS_PITCH   = 2'h2;
	localparam logic [1:0]  ADDRESS_ROLL    = 2'h1;
	localparam logic [1:0]  ADDRESS_VELOCITY = 2'h3;

	// ------------------------------------------------------------------
	// Types.
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b01,
		SEQ_ACTIVE = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic alert;                // Start of a command word.
		logic sync;                 // One-cycle strobe per bit.
		logic info;                 // Bit value, valid with sync.
	} command_link_t;

	typedef struct packed {
		logic pitch;
		logic roll;
		logic velocity;
	} duration_overflow_t;

	typedef struct packed {
		logic gyro_on_output;
		logic inertial_control_output;
		logic turn_polarity_output;
		logic pitch_torquer_select;
		logic roll_torquer_select;
		logic motor_ignite_pulse;
		logic motor_cutoff_pulse;
		logic maneuver_timing;
	} relay_outputs_t;

	typedef struct packed {
		logic pitch_power;
		logic roll_power;
		logic velocity_power;
		logic velocity_count_enable;
		logic sync_mc;
		logic info_mc;
	} duration_control_t;

endpackage

// File: logic/midcourse_maneuver_sequencer.sv
/*
 * Midcourse maneuver sequencer: minute clock with one-shot events, the
 * relay-style maneuver outputs, the serial command decoder with address
 * and polarity stores, and an AHB-Lite register slave.
 * Assumes every input is synchronous to hclk, sync and minute_tick are
 * one-cycle strobes, and the duration shift registers live outside.
 */
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module midcourse_maneuver_sequencer (
	input  wire logic                              hclk,
	input  wire logic                              hresetn,
	input  wire logic                              hsel,
	input  wire logic [31:0]                       haddr,
	input  wire logic [1:0]                        htrans,
	input  wire logic                              hwrite,
	input  wire logic [2:0]                        hsize,
	input  wire logic [31:0]                       hwdata,
	input  wire logic                              hready,
	output logic                                   hreadyout,
	output logic                                   hresp,
	output logic [31:0]                            hrdata,
	input  wire logic                              midcourse_start_command,
	input  wire logic                              minute_tick,
	input  wire midcourse_pkg::command_link_t      link,
	input  wire midcourse_pkg::duration_overflow_t overflow,
	output midcourse_pkg::relay_outputs_t          relays,
	output midcourse_pkg::duration_control_t       duration,
	output logic                                   parity_good_pulse,
	output logic                                   midcourse_clamp
);

	// ------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------
	midcourse_pkg::seq_state_t state;          // Idle or active midcourse.
	logic [7:0]                minute;         // Minutes since the start.
	logic                      time_zero;      // One-cycle start event.
	logic [3:0]                armed;          // One-shot arming, one per event.
	logic [3:0]                ev_fire;        // Registered event pulses.
	logic [3:0]                fire_cond;      // Event decode this cycle.
	logic [7:0]                ev_minute [4];  // Event minute table.
	logic                      ext_en;         // Start pin enable.
	logic                      soft_start;     // Start written by software.
	logic                      start_req;      // Any start request.
	logic                      active;
	logic                      tick_overflow;
	logic                      ev_pitch, ev_roll, ev_burn, ev_end;
	logic                      pitch_run, roll_run, velocity_run, count_enable;
	logic [2:0]                lo;             // Six-state section.
	logic [1:0]                hi;             // Three-state section.
	logic [1:0]                addr;           // Address bits four and five.
	logic                      parity;         // Running ones parity.
	logic                      pitch_pol, roll_pol;
	logic [4:0]                bits_rx;        // Bits received in this word.
	logic                      window;         // Bits six to seventeen.
	logic                      is_pitch, is_roll, is_velocity;
	logic                      addr_valid;
	logic                      bit18;
	logic [2:0]                next_lo;
	logic [1:0]                next_hi;
	midcourse_pkg::relay_outputs_t    next_relays;
	midcourse_pkg::duration_control_t next_duration;
	logic                      pitch_set, roll_set, polarity_set, timing_set;
	logic                      any_register_overflow;
	logic                      ap_valid, dp_write;
	logic [7:0]                dp_addr;
	logic [31:0]               read_mux;

	// ------------------------------------------------------------------
	// Bit counter decode helper.
	// ------------------------------------------------------------------
	// The high section steps when the low one enters its fifth state, so
	// the number of bits received is recovered from both sections.
	function automatic logic [4:0] bits_received(input logic [2:0] l, input logic [1:0] h);
		logic [1:0] k;
		k = h;
		if (l >= midcourse_pkg::LO_CARRY) begin
			k = (h == 2'h0) ? midcourse_pkg::HI_LAST : h - 2'h1;
		end
		return 5'(l) + {1'b0, k, 2'b00} + {2'b00, k, 1'b0};
	endfunction

	// ------------------------------------------------------------------
	// Start and minute counter.
	// ------------------------------------------------------------------
	assign active        = (state == midcourse_pkg::SEQ_ACTIVE);
	assign start_req     = (midcourse_start_command & ext_en) | soft_start;
	assign tick_overflow = active & minute_tick & (minute == (midcourse_pkg::MINUTE_OVERFLOW - 8'h01));
	assign midcourse_clamp = ~active;

	// Start leaves idle, releases the clamp and emits time zero; overflow
	// stops the counter at zero and reapplies the clamp.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= midcourse_pkg::SEQ_IDLE;
			minute    <= 8'h00;
			time_zero <= 1'b0;
		end else begin
			time_zero <= 1'b0;
			unique case (state)
				midcourse_pkg::SEQ_IDLE: begin
					if (start_req) begin
						state     <= midcourse_pkg::SEQ_ACTIVE;
						time_zero <= 1'b1;
					end
					minute <= 8'h00;
				end
				midcourse_pkg::SEQ_ACTIVE: begin
					if (tick_overflow) begin
						state  <= midcourse_pkg::SEQ_IDLE;
						minute <= 8'h00;
					end else if (minute_tick) begin
						minute <= minute + midcourse_pkg::MINUTE_STEP;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// One-shot event generators.
	// ------------------------------------------------------------------
	assign ev_minute[0] = midcourse_pkg::EV_PITCH_MIN;
	assign ev_minute[1] = midcourse_pkg::EV_ROLL_MIN;
	assign ev_minute[2] = midcourse_pkg::EV_BURN_MIN;
	assign ev_minute[3] = midcourse_pkg::EV_END_MIN;

	// The count holds each value for a whole minute, so the arming flag is
	// what keeps an event to a single pulse.
	for (genvar k = 0; k < 4; k++) begin : g_event
		assign fire_cond[k] = active & armed[k] & (minute == ev_minute[k]);
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				armed[k]   <= 1'b1;
				ev_fire[k] <= 1'b0;
			end else begin
				ev_fire[k] <= fire_cond[k];
				if (!active) begin
					armed[k] <= 1'b1;
				end else if (fire_cond[k]) begin
					armed[k] <= 1'b0;
				end
			end
		end
	end

	assign ev_pitch = ev_fire[0];
	assign ev_roll  = ev_fire[1];
	assign ev_burn  = ev_fire[2];
	assign ev_end   = ev_fire[3];

	// ------------------------------------------------------------------
	// Maneuver outputs.
	// ------------------------------------------------------------------
	assign any_register_overflow = overflow.pitch | overflow.roll | overflow.velocity;
	assign pitch_set    = ev_pitch & ~relays.roll_torquer_select & ~ev_roll;
	assign roll_set     = ev_roll;
	assign polarity_set = (ev_pitch & pitch_pol) | (ev_roll & roll_pol);
	assign timing_set   = ev_pitch | ev_roll | ev_burn;

	assign next_relays.gyro_on_output = time_zero | (relays.gyro_on_output & ~ev_end);
	assign next_relays.inertial_control_output = ev_pitch | (relays.inertial_control_output & ~ev_end);
	assign next_relays.turn_polarity_output = polarity_set |
		(relays.turn_polarity_output & ~overflow.pitch & ~overflow.roll & ~ev_end);
	assign next_relays.pitch_torquer_select = pitch_set |
		(relays.pitch_torquer_select & ~overflow.pitch & ~ev_end & ~roll_set);
	assign next_relays.roll_torquer_select = roll_set |
		(relays.roll_torquer_select & ~overflow.roll & ~ev_end);
	assign next_relays.motor_ignite_pulse = ev_burn & ~relays.pitch_torquer_select &
		~relays.roll_torquer_select;
	assign next_relays.motor_cutoff_pulse = overflow.velocity & velocity_run;
	assign next_relays.maneuver_timing = timing_set |
		(relays.maneuver_timing & ~ev_end & ~any_register_overflow);

	// All relay outputs come straight from flip-flops so downstream drivers never
	// see decode glitches.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			relays <= '0;
		end else begin
			relays <= next_relays;
		end
	end

	// Run flip-flops hold the duration registers on during the maneuver.
	// Velocity takes over when the roll register finishes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pitch_run    <= 1'b0;
			roll_run     <= 1'b0;
			velocity_run <= 1'b0;
			count_enable <= 1'b0;
		end else begin
			pitch_run    <= active & (ev_pitch | (pitch_run & ~overflow.pitch));
			roll_run     <= active & (ev_roll | (roll_run & ~overflow.roll));
			velocity_run <= active & ((roll_run & overflow.roll) | (velocity_run & ~overflow.velocity));
			count_enable <= active & (ev_burn | count_enable);
		end
	end

	// ------------------------------------------------------------------
	// Serial command decoder.
	// ------------------------------------------------------------------
	assign bits_rx     = bits_received(lo, hi);
	assign window      = (bits_rx >= midcourse_pkg::ADDR_BITS) & (bits_rx <= midcourse_pkg::WINDOW_LAST);
	assign is_pitch    = (addr == midcourse_pkg::ADDRESS_PITCH);
	assign is_roll     = (addr == midcourse_pkg::ADDRESS_ROLL);
	assign is_velocity = (addr == midcourse_pkg::ADDRESS_VELOCITY);
	assign addr_valid  = window & (is_pitch | is_roll | is_velocity);
	assign bit18       = link.sync & (bits_rx == midcourse_pkg::POLARITY_PREV);
	assign next_lo     = (lo == midcourse_pkg::LO_LAST) ? 3'h0 : lo + 3'h1;
	assign next_hi     = (next_lo != midcourse_pkg::LO_CARRY) ? hi :
	                     (hi == midcourse_pkg::HI_LAST) ? 2'h0 : hi + 2'h1;

	// Eight decoder flip-flops: counter, address pair and parity.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo     <= 3'h0;
			hi     <= 2'h0;
			addr   <= 2'h0;
			parity <= 1'b0;
		end else if (link.alert) begin
			lo     <= 3'h0;
			hi     <= 2'h0;
			addr   <= 2'h0;
			parity <= 1'b0;
		end else if (link.sync) begin
			lo     <= next_lo;
			hi     <= next_hi;
			if (bits_rx < midcourse_pkg::ADDR_BITS) begin
				addr <= {addr[0], link.info};
			end
			parity <= parity ^ link.info;
		end
	end

	// Polarity stores live outside the decoder, so an alert keeps them.
	// A load in the same cycle as a turn-on wins over the transfer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pitch_pol         <= 1'b0;
			roll_pol          <= 1'b0;
			parity_good_pulse <= 1'b0;
		end else begin
			parity_good_pulse <= bit18 & ~link.alert & (parity ^ link.info);
			if (bit18 & ~link.alert & link.info & is_pitch) begin
				pitch_pol <= 1'b1;
			end else if (ev_pitch) begin
				pitch_pol <= 1'b0;
			end
			if (bit18 & ~link.alert & link.info & is_roll) begin
				roll_pol <= 1'b1;
			end else if (ev_roll) begin
				roll_pol <= 1'b0;
			end
		end
	end

	// Sync pulses reach the shift registers only while clamped, so a
	// running sequence cannot be overwritten.
	assign next_duration.pitch_power           = pitch_run | (addr_valid & is_pitch);
	assign next_duration.roll_power            = roll_run | (addr_valid & is_roll);
	assign next_duration.velocity_power        = velocity_run | (addr_valid & is_velocity);
	assign next_duration.velocity_count_enable = count_enable;
	assign next_duration.sync_mc               = link.sync & ~link.alert & addr_valid & ~active;
	assign next_duration.info_mc               = link.sync & ~link.alert & addr_valid & link.info;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			duration <= '0;
		end else begin
			duration <= next_duration;
		end
	end

	// ------------------------------------------------------------------
	// AHB-Lite slave, zero wait states, always OKAY.
	// ------------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_valid  = hsel & hready & htrans[1];
	assign read_mux  = (haddr[7:0] == midcourse_pkg::ADDR_CONTROL) ?
		{30'h0000_0000, ext_en, 1'b0} :
		(haddr[7:0] == midcourse_pkg::ADDR_STATUS) ?
		{2'b00, duration, relays, minute, 7'h00, active} :
		(haddr[7:0] == midcourse_pkg::ADDR_DECODER) ?
		{14'h0000, roll_pol, pitch_pol, 3'h0, parity, 2'h0, addr, 2'h0, hi, 1'b0, lo} :
		32'h0000_0000;

	// Read data is captured at the address phase so it stands from a flop
	// during the data phase; writes land at the end of the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
			hrdata   <= 32'h0000_0000;
		end else begin
			dp_write <= ap_valid & hwrite;
			dp_addr  <= haddr[7:0];
			hrdata   <= (ap_valid & ~hwrite) ? read_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_en     <= midcourse_pkg::CTRL_EXT_EN_RESET;
			soft_start <= 1'b0;
		end else begin
			soft_start <= dp_write & (dp_addr == midcourse_pkg::ADDR_CONTROL) &
				hwdata[midcourse_pkg::CTRL_START_BIT];
			if (dp_write & (dp_addr == midcourse_pkg::ADDR_CONTROL)) begin
				ext_en <= hwdata[midcourse_pkg::CTRL_EXT_EN_BIT];
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence ignite_cause_s;
		ev_burn & ~relays.pitch_torquer_select & ~relays.roll_torquer_select;
	endsequence
	sequence ignite_once_s;
		relays.motor_ignite_pulse ##1 !relays.motor_ignite_pulse;
	endsequence

	start_time_zero_a: assert property (!active && start_req |=> active && time_zero)
		else $error("start did not enter active with time zero");
	minute_step_a: assert property (active && minute_tick && !tick_overflow |=> minute == $past(minute) + 8'h01)
		else $error("minute counter did not advance by one");
	event_once_a: assert property (ev_pitch |=> !ev_pitch [*8])
		else $error("pitch event fired twice");
	roll_minute_a: assert property (fire_cond[1] |-> minute == 8'h52 && active)
		else $error("roll event at wrong minute");
	timing_set_a: assert property (ev_burn && !ev_end |=> relays.maneuver_timing)
		else $error("timing indicator not set by burn");
	overflow_idle_a: assert property (tick_overflow |=> !active && minute == 8'h00 && midcourse_clamp)
		else $error("overflow did not return to idle");
	torquer_exclusive_a: assert property (!(relays.pitch_torquer_select && relays.roll_torquer_select))
		else $error("pitch and roll selected together");
	ignite_pulse_a: assert property (ignite_cause_s |=> ignite_once_s)
		else $error("ignite pulse wrong");
	end_clears_a: assert property (ev_end && !polarity_set |=> !relays.gyro_on_output && !relays.turn_polarity_output)
		else $error("end event did not clear outputs");
	alert_clears_a: assert property (link.alert |=> lo == 3'h0 && hi == 2'h0 && addr == 2'h0 && !parity)
		else $error("alert did not clear decoder");
	parity_good_a: assert property (bit18 && !link.alert && (parity ^ link.info) |=> parity_good_pulse)
		else $error("parity good missing");

endmodule

// File: tb/cmd_source.sv
/* Command source model: an alert, then the first n sync-framed bits of an 18-bit word, first bit first.
   Assumes send is called just after a rising edge of clk. */
`timescale 1ns/10ps
module cmd_source (
	input  wire logic                    clk,
	output midcourse_pkg::command_link_t link
);
	// Between syncs, info shows the inverse of the last bit, so no stale value can pass.
	initial link = '0;
	// A count below 18 cuts the word short, as a dropped link would.
	task automatic send(input logic [17:0] w, input int n);
		link <= 3'h4;
		@(posedge clk);
		for (int i = 17; i > 17 - n; i--) begin
			link <= {2'h1, w[i]};
			@(posedge clk);
			link <= {2'h0, ~w[i]};
			@(posedge clk);
		end
	endtask
endmodule

// File: tb/tb.sv
/* Top bench: bus reads queue expected words; a monitor compares them at the data phase.
   Assumes a zero-wait slave and a command source model beside the design. */
`timescale 1ns/10ps
module tb;
	logic                              hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdp = 0, tick = 0, start = 0;
	logic [31:0]                       haddr = '0, hwdata = '0, hrdata;
	logic [1:0]                        htrans = '0;
	logic                              hreadyout, hresp, pgood, clamp;
	midcourse_pkg::command_link_t      link;
	midcourse_pkg::duration_overflow_t ovf = '0;
	midcourse_pkg::relay_outputs_t     relays;
	midcourse_pkg::duration_control_t  dur;
	logic [63:0]                       q[$];
	int                                errors = 0, cmp_count = 0, ign = 0, cut = 0, pg = 0, smc = 0;
	localparam logic [31:0]            M = 32'h00FF_FF01;
	midcourse_maneuver_sequencer midcourse_maneuver_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .midcourse_start_command(start),
		.minute_tick(tick), .link(link), .overflow(ovf), .relays(relays), .duration(dur),
		.parity_good_pulse(pgood), .midcourse_clamp(clamp));
	cmd_source cmd_source_i (.clk(hclk), .link(link));
	initial forever #10 hclk = ~hclk;
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	// One single transfer; a read queues {expected, mask} for the monitor.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [63:0] em);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		rdp <= !w;
		if (!w) q.push_back(em);
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rdp <= 1'b0;
	endtask
	// The monitor takes the oldest note at the edge where read data is sampled.
	always @(posedge hclk) begin
		if (rdp && hreadyout === 1'b1 && q.size() > 0) begin
			chk("hrdata", hrdata & q[0][31:0], q[0][63:32]);
			void'(q.pop_front());
		end
		if (relays.motor_ignite_pulse === 1'b1) ign++;
		if (relays.motor_cutoff_pulse === 1'b1) cut++;
		if (pgood === 1'b1) pg++;
		if (dur.sync_mc === 1'b1) smc++;
	end
	// Minute ticks with random gaps, then time for the event pipeline to settle.
	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge hclk);
			tick <= 1'b0;
			repeat ($urandom_range(3, 1)) @(posedge hclk);
		end
		repeat (4) @(posedge hclk);
	endtask
	task automatic pulse(input logic [2:0] v);
		ovf <= v;
		@(posedge hclk);
		ovf <= '0;
		repeat (4) @(posedge hclk);
	endtask
	// Random payload; bit six is the parity bit chosen so that the word holds an odd count of ones.
	function automatic logic [17:0] word(input logic [4:0] ad, input logic pol);
		logic [10:0] r;
		r = 11'($urandom);
		return {ad, ~^{ad, r, pol}, r, pol};
	endfunction
	task automatic complete_run;
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		complete_run();
	end
	initial begin
		void'($urandom(8));
		repeat (8) @(posedge hclk);
		chk("clamp", {31'h0000_0000, clamp}, 32'h0000_0001);
		hresetn <= 1'b1;
		@(posedge hclk);
		cmd_source_i.send(word(5'h0E, 1'b1), 18);
		xfer(8'h08, 1'b0, '0, {32'h0001_1200, 32'h0001_1337});
		// A cut word with a dead address leaves the counter mid-word for the next alert to clear.
		cmd_source_i.send(word(5'h00, 1'b1), 7);
		cmd_source_i.send(word(5'h01, 1'b0), 18);
		xfer(8'h08, 1'b0, '0, {32'h0001_1100, 32'h0003_1337});
		chk("parity_good", pg, 32'h0000_0002);
		chk("sync_mc", smc, 32'h0000_0018);
		xfer(8'h40, 1'b0, '0, {32'h0000_0000, 32'hFFFF_FFFF});
		xfer(8'h00, 1'b1, 32'h0000_0003, '0);
		repeat (3) @(posedge hclk);
		xfer(8'h04, 1'b0, '0, {32'h0080_0001, M});
		chk("clamp", {31'h0000_0000, clamp}, 32'h0000_0000);
		ticks(60);
		xfer(8'h00, 1'b1, 32'h0000_0003, '0);
		xfer(8'h04, 1'b0, '0, {32'h00F1_3C01, M});
		pulse(3'h4);
		xfer(8'h04, 1'b0, '0, {32'h00C0_3C01, M});
		ticks(22);
		xfer(8'h04, 1'b0, '0, {32'h00C9_5201, M});
		pulse(3'h2);
		xfer(8'h04, 1'b0, '0, {32'h00C0_5201, M});
		ticks(22);
		xfer(8'h04, 1'b0, '0, {32'h04C1_6801, 32'h04FF_FF01});
		pulse(3'h1);
		xfer(8'h04, 1'b0, '0, {32'h00C0_6801, M});
		ticks(6);
		xfer(8'h04, 1'b0, '0, {32'h0000_6E01, M});
		ticks(89);
		xfer(8'h04, 1'b0, '0, {32'h0000_0000, M});
		chk("clamp", {31'h0000_0000, clamp}, 32'h0000_0001);
		// A pin start after the overflow must find the pitch event re-armed.
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		ticks(60);
		xfer(8'h04, 1'b0, '0, {32'h00D1_3C01, M});
		chk("ignite", ign, 32'h0000_0001);
		chk("cutoff", cut, 32'h0000_0001);
		complete_run();
	end
endmodule
